/* src/sram_host_ctrl.sv */
// host controller that drives an asynchronous 256K x 32 static memory module
`timescale 1ns/1ps
module sram_host_ctrl (
   input  wire logic                                   clk_i,
   input  wire logic                                   reset_i,
   input  wire logic                                   req_valid_i,
   input  wire logic                                   req_write_i,
   input  wire logic [sram_host_pkg::ADDR_W-1:0]       req_addr_i,
   input  wire logic [sram_host_pkg::DATA_W-1:0]       req_wdata_i,
   input  wire logic [sram_host_pkg::LANES-1:0]        req_lanes_i,
   output logic                                        req_ready_o,
   output logic                                        rsp_valid_o,
   output logic [sram_host_pkg::DATA_W-1:0]            rsp_rdata_o,
   output logic                                        depth_ok_o,
   output logic [sram_host_pkg::ADDR_W-1:0]            word_address_o,
   output logic [sram_host_pkg::LANES-1:0]             byte_lane_select_n_o,
   output logic                                        write_strobe_n_o,
   output logic                                        output_enable_n_o,
   output logic [sram_host_pkg::DATA_W-1:0]            data_bus_o,
   output logic                                        data_bus_oe_o,
   input  wire logic [sram_host_pkg::DATA_W-1:0]       data_bus_i,
   input  wire logic                                   depth_id_bit0_i,
   input  wire logic                                   depth_id_bit1_i
);
   // data is taken only after the access time and both sync stages have passed;
   // the counter runs down to zero, so one cycle less than that sum is loaded
   localparam int unsigned SYNC_STAGES = 2;
   localparam int unsigned READ_WAIT   = sram_host_pkg::READ_CYC + SYNC_STAGES - 1;

   sram_host_pkg::state_e state, next_state;
   logic [sram_host_pkg::CNT_W-1:0]  cnt, next_cnt;
   logic                              is_write, next_is_write;
   logic [sram_host_pkg::ADDR_W-1:0]  next_addr;
   logic [sram_host_pkg::LANES-1:0]   lanes, next_lanes;
   logic [sram_host_pkg::LANES-1:0]   next_sel_n;
   logic                              next_we_n, next_oe_n, next_bus_oe, next_ready;
   logic                              next_rsp_valid;
   logic [sram_host_pkg::DATA_W-1:0]  next_wdata, next_rdata;
   // two-flop sync of the static depth straps
   logic [1:0]                        depth_meta, depth_sync;
   logic                              next_depth_ok;
   logic [sram_host_pkg::DATA_W-1:0]  rd_meta, rd_sync;

   // synchronisers: module pins are outside our clock domain
   // the data word is multi-bit, but the selects hold it still across the whole
   // capture window, so no half-changed word can reach rsp_rdata_o
   always_ff @(posedge clk_i) begin
      depth_meta <= {depth_id_bit1_i, depth_id_bit0_i};
      depth_sync <= depth_meta;
      rd_meta    <= data_bus_i;
      rd_sync    <= rd_meta;
   end

   // depth straps both low flag a 256K module
   // straps never move in service; the sync pair only guards the power-up ramp
   always_comb begin
      next_depth_ok = (depth_sync == sram_host_pkg::DEPTH_256K);
   end

   // depth flag register; low through reset until the straps are seen
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         depth_ok_o <= 1'b0;
      end else begin
         depth_ok_o <= next_depth_ok;
      end
   end

   // next-state logic of the access sequencer
   always_comb begin
      // every register holds its value unless a state below moves it
      next_state     = state;
      next_cnt       = cnt;
      next_is_write  = is_write;
      next_addr      = word_address_o;
      next_lanes     = lanes;
      next_sel_n     = byte_lane_select_n_o;
      next_we_n      = write_strobe_n_o;
      next_oe_n      = output_enable_n_o;
      next_bus_oe    = data_bus_oe_o;
      next_wdata     = data_bus_o;
      // ready and response are pulses unless a state raises them
      next_ready     = 1'b0;
      next_rsp_valid = 1'b0;
      next_rdata     = rsp_rdata_o;
      // one branch per state; each moves only what changes at its edge
      case (state)
         sram_host_pkg::ST_IDLE: begin
            // ready stands while idle and drops the cycle after a take
            next_ready = 1'b1;
            if (req_valid_i && req_ready_o) begin
               // address moves only with every select and strobe high
               next_addr     = req_addr_i;
               next_lanes    = req_lanes_i;
               next_is_write = req_write_i;
               next_wdata    = req_wdata_i;
               next_ready    = 1'b0;
               next_state    = sram_host_pkg::ST_SETUP;
            end
         end
         sram_host_pkg::ST_SETUP: begin
            // one cycle of address setup before any select falls
            if (is_write) begin
               // strobe falls together with selects so outputs stay off
               next_we_n   = 1'b0;
               next_oe_n   = 1'b1;
               next_bus_oe = 1'b1;
               next_cnt    = sram_host_pkg::CNT_W'(sram_host_pkg::WRITE_CYC);
               next_state  = sram_host_pkg::ST_WRITE;
            end else begin
               // read: output enable falls with the selects, strobe stays high
               next_oe_n  = 1'b0;
               next_cnt   = sram_host_pkg::CNT_W'(READ_WAIT);
               next_state = sram_host_pkg::ST_READ;
            end
            // selects fall at the same edge as the strobe: the write is controlled by both
            next_sel_n = ~lanes; // unselected lanes stay in standby
         end
         sram_host_pkg::ST_READ: begin
            // count out the access time plus the sync latency
            next_cnt = cnt - 1'b1;
            if (cnt == '0) begin
               // two sync stages add latency; data is held by selects until here
               next_rdata     = rd_sync;
               next_rsp_valid = 1'b1;
               next_sel_n     = '1;
               next_oe_n      = 1'b1;
               next_cnt       = sram_host_pkg::CNT_W'(sram_host_pkg::TURN_CYC);
               next_state     = sram_host_pkg::ST_HOLD;
            end else if (cnt == sram_host_pkg::CNT_W'(1)) begin
               next_cnt = '0;
            end
         end
         sram_host_pkg::ST_WRITE: begin
            // count out the strobe-low time
            next_cnt = cnt - 1'b1;
            if (cnt == sram_host_pkg::CNT_W'(1)) begin
               // strobe and selects rise together, ending the overlap
               next_we_n      = 1'b1;
               next_sel_n     = '1;
               next_rsp_valid = 1'b1;
               next_cnt       = sram_host_pkg::CNT_W'(sram_host_pkg::TURN_CYC);
               next_state     = sram_host_pkg::ST_HOLD;
            end
         end
         sram_host_pkg::ST_HOLD: begin
            // data held one cycle past overlap end, then bus released
            // the turnaround count also covers module drivers leaving a read
            next_bus_oe = 1'b0;
            next_cnt    = cnt - 1'b1;
            if (cnt <= sram_host_pkg::CNT_W'(1)) begin
               next_cnt   = '0;
               next_ready = 1'b1;
               next_state = sram_host_pkg::ST_IDLE;
            end
         end
         default: begin
            // unknown code: park the pins in standby and restart from idle
            next_state = sram_host_pkg::ST_IDLE;
            next_sel_n = '1;
            next_we_n  = 1'b1;
            next_oe_n  = 1'b1;
            next_bus_oe = 1'b0;
         end
      endcase
      // the read path reads only after the host bus is released
      if (next_bus_oe) begin
         next_oe_n = 1'b1;
      end
   end

   // sequencer registers; all pin outputs come from here
   // so that no decode glitch can ever reach a strobe or select of the module
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         // reset parks the module in standby with the host off the bus
         state                <= sram_host_pkg::ST_IDLE;
         cnt                  <= '0;
         is_write             <= 1'b0;
         lanes                <= '0;
         word_address_o       <= '0;
         byte_lane_select_n_o <= '1;
         write_strobe_n_o     <= 1'b1;
         output_enable_n_o    <= 1'b1;
         data_bus_oe_o        <= 1'b0;
         data_bus_o           <= '0;
         req_ready_o          <= 1'b0;
         rsp_valid_o          <= 1'b0;
         rsp_rdata_o          <= '0;
      end else begin
         // register the next values only
         state                <= next_state;
         cnt                  <= next_cnt;
         is_write             <= next_is_write;
         lanes                <= next_lanes;
         word_address_o       <= next_addr;
         byte_lane_select_n_o <= next_sel_n;
         write_strobe_n_o     <= next_we_n;
         output_enable_n_o    <= next_oe_n;
         data_bus_oe_o        <= next_bus_oe;
         data_bus_o           <= next_wdata;
         req_ready_o          <= next_ready;
         rsp_valid_o          <= next_rsp_valid;
         rsp_rdata_o          <= next_rdata;
      end
   end
endmodule : sram_host_ctrl

/* src/sram_host_pkg.sv */
// package: constants for the asynchronous static memory module host controller
package sram_host_pkg;
   localparam int unsigned ADDR_W       = 18;
   localparam int unsigned DATA_W       = 32;
   localparam int unsigned LANES        = 4;
   localparam int unsigned LANE_W       = 8;
   localparam int unsigned CLK_PERIOD_NS = 25;
   // module timing figures in ns, slowest grade assumed
   localparam int unsigned T_ACCESS_NS  = 45;
   localparam int unsigned T_WRITE_PULSE_NS = 35;
   localparam int unsigned T_WE_HIZ_NS  = 23;
   localparam int unsigned T_DATA_OVERLAP_NS = 25;
   localparam int unsigned T_OUT_HIZ_NS = 20;
   // least times round up to whole cycles
   localparam int unsigned READ_CYC =
      (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WP_MIN_NS =
      (T_WRITE_PULSE_NS > T_WE_HIZ_NS + T_DATA_OVERLAP_NS) ?
      T_WRITE_PULSE_NS : (T_WE_HIZ_NS + T_DATA_OVERLAP_NS);
   localparam int unsigned WRITE_CYC =
      (WP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TURN_CYC =
      (T_OUT_HIZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 3;
   localparam logic [1:0] DEPTH_256K = 2'h0;
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_SETUP = 5'h02,
      ST_READ  = 5'h04,
      ST_WRITE = 5'h08,
      ST_HOLD  = 5'h10
   } state_e;
endpackage : sram_host_pkg

/* testbench/sram_host_ctrl_sva.sv */
// checker for the controller's memory-side pins
`timescale 1ns/1ps
module sram_host_ctrl_sva (
   input wire logic        clk_i,
   input wire logic        reset_i,
   input wire logic        rsp_valid_o,
   input wire logic [17:0] word_address_o,
   input wire logic [3:0]  byte_lane_select_n_o,
   input wire logic        write_strobe_n_o,
   input wire logic        output_enable_n_o,
   input wire logic [31:0] data_bus_o,
   input wire logic        data_bus_oe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // write pulse is two cycles, ending with strobe and selects together
   sequence wr_low; !write_strobe_n_o [*2]; endsequence
   sequence wr_end; write_strobe_n_o && (&byte_lane_select_n_o); endsequence
   a_addr_quiet: assert property (!$stable(word_address_o) |->
      write_strobe_n_o && $past(write_strobe_n_o) && (&byte_lane_select_n_o))
      else $error("address moved while strobe low");
   a_pulse_width: assert property ($fell(write_strobe_n_o) |-> wr_low ##1 wr_end)
      else $error("write pulse not two cycles");
   a_rise_together: assert property ($rose(write_strobe_n_o) |-> wr_end and rsp_valid_o)
      else $error("strobe and selects do not end together");
   a_bus_turn: assert property (data_bus_oe_o |->
      output_enable_n_o && $past(output_enable_n_o))
      else $error("host drives bus while module may drive");
   a_data_hold: assert property (!write_strobe_n_o && !$past(write_strobe_n_o) |->
      data_bus_oe_o && $stable(data_bus_o))
      else $error("write data moved during overlap");
   a_bus_release: assert property ($rose(write_strobe_n_o) |=> !data_bus_oe_o)
      else $error("bus not released after write");
   a_read_len: assert property ($fell(output_enable_n_o) |-> ##4
      (rsp_valid_o && output_enable_n_o && (&byte_lane_select_n_o)))
      else $error("read cycle length wrong");
endmodule : sram_host_ctrl_sva
bind sram_host_ctrl sram_host_ctrl_sva u_sva (.clk_i, .reset_i, .rsp_valid_o, .word_address_o,
   .byte_lane_select_n_o, .write_strobe_n_o, .output_enable_n_o, .data_bus_o, .data_bus_oe_o);

/* testbench/sram_host_ctrl_tb.sv */
// self-checking bench: host controller against the behavioural module
`timescale 1ns/1ps
module sram_host_ctrl_tb;
   logic        clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        req_valid = 1'b0;
   logic        req_write = 1'b0;
   logic [17:0] req_addr = 18'h0;
   logic [31:0] req_wdata = 32'h0;
   logic [3:0]  req_lanes = 4'h0;
   logic        ready, rsp_valid, depth_ok, we_n, oe_n, bus_oe;
   logic [31:0] rdata, bus_q, bus_d;
   logic [31:0] shadow [logic [17:0]];
   logic [17:0] addr, ra;
   logic [3:0]  sel_n;
   logic [1:0]  depth;
   int          error_cnt = 0;
   int          checks = 0;
   always #12.5 clk_i = ~clk_i;  // 40 MHz
   sram_host_ctrl uut (.clk_i, .reset_i, .req_valid_i(req_valid), .req_write_i(req_write),
      .req_addr_i(req_addr), .req_wdata_i(req_wdata), .req_lanes_i(req_lanes),
      .req_ready_o(ready), .rsp_valid_o(rsp_valid), .rsp_rdata_o(rdata), .depth_ok_o(depth_ok),
      .word_address_o(addr), .byte_lane_select_n_o(sel_n), .write_strobe_n_o(we_n),
      .output_enable_n_o(oe_n), .data_bus_o(bus_d), .data_bus_oe_o(bus_oe), .data_bus_i(bus_q),
      .depth_id_bit0_i(depth[0]), .depth_id_bit1_i(depth[1]));
   sram_module_model module_model (.addr_i(addr), .sel_n_i(sel_n), .we_n_i(we_n),
      .oe_n_i(oe_n), .host_d_i(bus_d), .host_oe_i(bus_oe), .bus_o(bus_q), .depth_o(depth));
   // expected word from the bench's own shadow copy
   function automatic logic [31:0] expect_word(input logic [17:0] a);
      expect_word = shadow.exists(a) ? shadow[a] : 32'h0;
   endfunction : expect_word
   task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] seen);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : cmp32
   task automatic cmp1(input string what, input logic exp, input logic seen);
      cmp32(what, {31'h0, exp}, {31'h0, seen});
   endtask : cmp1
   // one request, held until taken; unselected read bytes are masked off
   task automatic xfer(input logic wr, input logic [17:0] a, input logic [31:0] d,
                       input logic [3:0] ln);
      int n;
      logic [31:0] m;
      n = 0;
      m = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
      while (ready !== 1'b1 && n++ < 40) @(negedge clk_i);
      {req_valid, req_write, req_addr, req_wdata, req_lanes} = {1'b1, wr, a, d, ln};
      @(negedge clk_i);
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n++ < 40) @(negedge clk_i);
      if (n >= 40) begin
         error_cnt++;
         $display("ERROR response expected 1 seen %b", rsp_valid);
         end_sim;
      end
      if (wr) shadow[a] = (expect_word(a) & ~m) | (d & m);
      else cmp32("read data", expect_word(a) & m, rdata & m);
      @(negedge clk_i);
   endtask : xfer
   task automatic end_sim;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   // main sequence: straps, single lanes at the top word, then random traffic
   initial begin
      void'($urandom(32'h09dffe66));
      repeat (5) @(negedge clk_i);
      reset_i = 1'b0;
      repeat (5) @(negedge clk_i);
      cmp1("depth ok", 1'b1, depth_ok);
      $display("test depth done");
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, 18'h3ffff, $urandom, 4'h1 << i);
         xfer(1'b0, 18'h3ffff, 32'h0, 4'hf);
      end
      $display("test lanes done");
      for (int i = 0; i < 40; i++) begin
         ra = ($urandom_range(1) ? 18'h3fff8 : 18'h0) | 18'($urandom_range(7));
         xfer(1'($urandom_range(1)), ra, $urandom, 4'($urandom_range(15, 1)));
      end
      $display("test random done");
      end_sim;
   end
   // watchdog well beyond the expected few hundred cycles
   initial begin
      #125000;
      error_cnt++;
      $display("ERROR watchdog expected done seen timeout");
      end_sim;
   end
endmodule : sram_host_ctrl_tb

/* testbench/sram_module_model.sv */
// behavioural memory module: no clock, byte lanes, shared bus
`timescale 1ns/1ps
module sram_module_model (
   input  wire logic [17:0] addr_i,
   input  wire logic [3:0]  sel_n_i,
   input  wire logic        we_n_i,
   input  wire logic        oe_n_i,
   input  wire logic [31:0] host_d_i,
   input  wire logic        host_oe_i,
   output logic [31:0]      bus_o,
   output logic [1:0]       depth_o
);
   logic [31:0] mem [logic [17:0]];  // sparse 256K x 32 store
   logic [31:0] last = 32'h0;
   assign depth_o = 2'h0;  // both straps at ground
   // writes land during select and strobe overlap, oe ignored
   always @(addr_i or sel_n_i or we_n_i or host_d_i) begin
      for (int i = 0; i < 4; i++) begin
         if (!sel_n_i[i] && !we_n_i) begin
            if (!mem.exists(addr_i)) mem[addr_i] = 32'h0;
            mem[addr_i][8*i+:8] = host_d_i[8*i+:8];
         end
      end
   end
   // floating lanes show the inverse of the last level, not a kind value
   always @(addr_i or sel_n_i or we_n_i or oe_n_i or host_d_i or host_oe_i) begin
      for (int i = 0; i < 4; i++) begin
         if (host_oe_i) bus_o[8*i+:8] = host_d_i[8*i+:8];
         else if (!sel_n_i[i] && !oe_n_i && we_n_i)
            bus_o[8*i+:8] = mem.exists(addr_i) ? mem[addr_i][8*i+:8] : 8'h00;
         else bus_o[8*i+:8] = ~last[8*i+:8];
      end
      last = bus_o;
   end
endmodule : sram_module_model
